// ---- hw/lsrs_pkg.sv ----
// Package for the link sync and reference select block.
// Assumes one 125 MHz clock (sys_clk) and a synchronous active-high reset.
package lsrs_pkg;

  // ==========================================================================
  // Timing counts
  // ==========================================================================
  localparam int unsigned LSRS_CLK_MHZ  = 125;           // System clock rate
  localparam int unsigned LSRS_LMFC_CYC = 16;            // Cycles per multiframe
  localparam int unsigned LSRS_ILAS_MF  = 4;             // Multiframes of alignment
  localparam int unsigned LSRS_CNT_W    = 4;             // Multiframe counter width
  localparam int unsigned LSRS_MF_W     = 2;             // Alignment count width
  localparam int unsigned LSRS_ILAS_CYC = LSRS_LMFC_CYC * LSRS_ILAS_MF;  // Alignment cycles

  localparam logic [LSRS_CNT_W-1:0] LSRS_LMFC_LAST = LSRS_CNT_W'(LSRS_LMFC_CYC - 1);
  localparam logic [LSRS_MF_W-1:0]  LSRS_ILAS_LAST = LSRS_MF_W'(LSRS_ILAS_MF - 1);

  // ==========================================================================
  // Field encodings and reset values
  // ==========================================================================
  localparam logic [1:0] LSRS_SYNC_SEL_SE  = 2'h0;       // Single-ended sync pin
  localparam logic [1:0] LSRS_SYNC_SEL_TS  = 2'h1;       // Timestamp pair as sync
  localparam logic [1:0] LSRS_SYNC_SEL_ALT = 2'h2;       // Alternate sync pin
  localparam logic       LSRS_SYNC_N_RST   = 1'h1;       // Sync idles released
  localparam logic       LSRS_LEVEL_RST    = 1'h0;       // Other inputs idle low
  localparam logic [LSRS_CNT_W-1:0] LSRS_CNT_RST = '0;   // Multiframe phase
  localparam logic [LSRS_MF_W-1:0]  LSRS_MF_RST  = '0;   // Alignment count

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [2:0] {
    LINK_IDLE,
    LINK_CGS,
    LINK_ALIGN,
    LINK_ILAS,
    LINK_DATA
  } lsrs_link_e;

  // Lane phase flags, at most one high; none while idle or waiting for the alignment boundary
  typedef struct packed {
    logic cgs;    // Code group sync characters
    logic ilas;   // Lane alignment sequence
    logic data;   // User data
  } lsrs_lane_s;

  localparam lsrs_lane_s LSRS_LANE_RST = '{cgs: 1'h0, ilas: 1'h0, data: 1'h0};

endpackage

// ---- hw/lsrs_sync_ref.sv ----
// Link sync request handling, PLL reference selection and SYSREF alignment.
// Assumes the reference, sync and SYSREF pins are asynchronous to sys_clk and pass the input filter.
`timescale 1ns/10ps

// ============================================================================
// Input filter: three flops and an output flop that follows once stages two and three agree
// ============================================================================
module lsrs_in_filt
  import lsrs_pkg::*;
#(
  parameter logic RST_VAL = 1'h0
)(
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level_q
);
  logic s1_q, s2_q, s3_q;    // Synchroniser stages
  logic s1_d, s2_d, s3_d;
  logic level_d;             // Filtered level

  // Next values; only stage two and three are compared
  always_comb
  begin
    s1_d    = pin;
    s2_d    = s1_q;
    s3_d    = s2_q;
    level_d = (s2_q == s3_q) ? s3_q : level_q;
  end

  // Registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s1_q    <= RST_VAL;
      s2_q    <= RST_VAL;
      s3_q    <= RST_VAL;
      level_q <= RST_VAL;
    end
    else
    begin
      s1_q    <= s1_d;
      s2_q    <= s2_d;
      s3_q    <= s3_d;
      level_q <= level_d;
    end
  end
endmodule

// ============================================================================
// Top: link state, reference select, SYSREF alignment
// ============================================================================
module lsrs_sync_ref
  import lsrs_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       pll_use,                    // PLL enable pin
  input  wire logic       ref_source_select,          // High picks single-ended ref
  input  wire logic       single_ended_ref_input,     // Single-ended reference
  input  wire logic       diff_clk_input,             // Differential clock, received
  input  wire logic       link_mode_64b66b,           // High: 64B/66B coding
  input  wire logic [1:0] sync_source_select,         // Which pin carries sync
  input  wire logic       single_ended_sync_input_n,  // Active-low sync request
  input  wire logic       timestamp_input_n,          // Timestamp pair used as sync
  input  wire logic       alternate_sync_input_n,     // Alternate sync request
  input  wire logic       sysref_receiver_power,      // SYSREF receiver enable
  input  wire logic       sysref_in,                  // SYSREF, received
  output lsrs_lane_s      lane_q,                     // Lane phase flags
  output logic            pll_ref_q,                  // Chosen PLL reference
  output logic            ref_is_se_q,                // Single-ended ref in use
  output logic            sysref_evt_q,               // One-cycle SYSREF edge
  output logic            lmfc_tick_q                 // Multiframe boundary pulse
);

  // ==========================================================================
  // Input filters
  // ==========================================================================
  logic se_ref_f, diff_f, se_sync_n_f, ts_n_f, alt_n_f, sysref_f;

  lsrs_in_filt #(.RST_VAL(LSRS_LEVEL_RST)) u_se_ref (
    .sys_clk(sys_clk), .rst(rst), .pin(single_ended_ref_input), .level_q(se_ref_f));
  lsrs_in_filt #(.RST_VAL(LSRS_LEVEL_RST)) u_diff (
    .sys_clk(sys_clk), .rst(rst), .pin(diff_clk_input), .level_q(diff_f));
  lsrs_in_filt #(.RST_VAL(LSRS_SYNC_N_RST)) u_se_sync (
    .sys_clk(sys_clk), .rst(rst), .pin(single_ended_sync_input_n), .level_q(se_sync_n_f));
  lsrs_in_filt #(.RST_VAL(LSRS_SYNC_N_RST)) u_ts (
    .sys_clk(sys_clk), .rst(rst), .pin(timestamp_input_n), .level_q(ts_n_f));
  lsrs_in_filt #(.RST_VAL(LSRS_SYNC_N_RST)) u_alt (
    .sys_clk(sys_clk), .rst(rst), .pin(alternate_sync_input_n), .level_q(alt_n_f));
  // Gated before the filter so a floating pin cannot toggle when powered down
  lsrs_in_filt #(.RST_VAL(LSRS_LEVEL_RST)) u_sysref (
    .sys_clk(sys_clk), .rst(rst), .pin(sysref_in & sysref_receiver_power),
    .level_q(sysref_f));

  // ==========================================================================
  // Sync request source
  // ==========================================================================
  logic sync_req;   // High while the receiver asks for resync

  // Mode and select picked here; 64B/66B never sees a request
  always_comb
  begin
    sync_req = 1'h0;
    if (!link_mode_64b66b)
    begin
      unique case (sync_source_select)
        LSRS_SYNC_SEL_SE:  sync_req = !se_sync_n_f;
        LSRS_SYNC_SEL_TS:  sync_req = !ts_n_f;
        LSRS_SYNC_SEL_ALT: sync_req = !alt_n_f;
        default:           sync_req = 1'h0;                  // Unused code
      endcase
    end
  end

  // ==========================================================================
  // Reference select and SYSREF edge
  // ==========================================================================
  logic pll_ref_d, ref_is_se_d, sysref_evt_d, sysref_dly_q, sysref_dly_d;

  // Reference mux; no PLL means no reference driven
  always_comb
  begin
    ref_is_se_d  = pll_use && ref_source_select;
    if (!pll_use)
      pll_ref_d = 1'h0;
    else if (ref_source_select)
      pll_ref_d = se_ref_f;
    else
      pll_ref_d = diff_f;
    sysref_dly_d = sysref_f;
    // Powered-down receiver yields no edge at all
    sysref_evt_d = sysref_receiver_power && sysref_f && !sysref_dly_q;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      pll_ref_q    <= LSRS_LEVEL_RST;
      ref_is_se_q  <= LSRS_LEVEL_RST;
      sysref_dly_q <= LSRS_LEVEL_RST;
      sysref_evt_q <= LSRS_LEVEL_RST;
    end
    else
    begin
      pll_ref_q    <= pll_ref_d;
      ref_is_se_q  <= ref_is_se_d;
      sysref_dly_q <= sysref_dly_d;
      sysref_evt_q <= sysref_evt_d;
    end
  end

  // ==========================================================================
  // Multiframe counter
  // ==========================================================================
  logic [LSRS_CNT_W-1:0] lmfc_cnt_q, lmfc_cnt_d;   // Phase within multiframe
  logic                  lmfc_tick_d;

  // SYSREF edge restarts the phase so latency is repeatable
  always_comb
  begin
    if (sysref_evt_q)
      lmfc_cnt_d = LSRS_CNT_RST;
    else if (lmfc_cnt_q == LSRS_LMFC_LAST)
      lmfc_cnt_d = LSRS_CNT_RST;
    else
      lmfc_cnt_d = lmfc_cnt_q + LSRS_CNT_W'(1);
    lmfc_tick_d = !sysref_evt_q && (lmfc_cnt_q == LSRS_LMFC_LAST);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      lmfc_cnt_q  <= LSRS_CNT_RST;
      lmfc_tick_q <= LSRS_LEVEL_RST;
    end
    else
    begin
      lmfc_cnt_q  <= lmfc_cnt_d;
      lmfc_tick_q <= lmfc_tick_d;
    end
  end

  // ==========================================================================
  // Link state machine
  // ==========================================================================
  lsrs_link_e             state_q, state_d;
  logic [LSRS_MF_W-1:0]   mf_q, mf_d;       // Alignment multiframes sent
  lsrs_lane_s             lane_d;

  // A request wins over every other step, so a resync is never lost
  always_comb
  begin
    state_d = state_q;
    mf_d    = mf_q;
    if (link_mode_64b66b)
      state_d = LINK_DATA;
    else if (sync_req)
    begin
      state_d = LINK_CGS;
      mf_d    = LSRS_MF_RST;
    end
    else
    begin
      unique case (state_q)
        LINK_IDLE:  state_d = LINK_IDLE;   // Wait for first request
        LINK_CGS:   state_d = LINK_ALIGN;  // Released high
        // Alignment starts on a boundary so every lane agrees
        LINK_ALIGN: if (lmfc_tick_q) state_d = LINK_ILAS;
        LINK_ILAS:
          if (lmfc_tick_q)
          begin
            if (mf_q == LSRS_ILAS_LAST)
              state_d = LINK_DATA;
            else
              mf_d = mf_q + LSRS_MF_W'(1);
          end
        LINK_DATA:  state_d = LINK_DATA;
      endcase
    end
    lane_d.cgs  = (state_d == LINK_CGS);
    lane_d.ilas = (state_d == LINK_ILAS);
    lane_d.data = (state_d == LINK_DATA);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_q <= LINK_IDLE;
      mf_q    <= LSRS_MF_RST;
      lane_q  <= LSRS_LANE_RST;
    end
    else
    begin
      state_q <= state_d;
      mf_q    <= mf_d;
      lane_q  <= lane_d;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_released;
    lane_q.cgs ##1 !lane_q.cgs;
  endsequence

  a_se_ref_pick: assert property (pll_use && ref_source_select |=>
    pll_ref_q == $past(se_ref_f) && ref_is_se_q)
    else $error("single-ended reference not chosen");
  a_diff_ref_pick: assert property (pll_use && !ref_source_select |=>
    pll_ref_q == $past(diff_f) && !ref_is_se_q)
    else $error("differential reference not chosen");
  a_se_sync_only: assert property (!link_mode_64b66b &&
    sync_source_select == LSRS_SYNC_SEL_SE && se_sync_n_f |=> !lane_q.cgs)
    else $error("sync seen from an unselected pin");
  a_mode64_ignore: assert property (link_mode_64b66b |=>
    lane_q.data && !lane_q.cgs)
    else $error("64b66b link not straight to data");
  a_cgs_start: assert property (sync_req |=> lane_q.cgs && !lane_q.ilas)
    else $error("sync request did not start cgs");
  a_ilas_after: assert property (s_released |-> !lane_q.ilas)
    else $error("alignment began without waiting a boundary");
  a_ilas_cause: assert property ($rose(lane_q.ilas) |-> !$past(sync_req))
    else $error("alignment began under a sync request");
  a_sysref_align: assert property (sysref_evt_q |=>
    lmfc_cnt_q == LSRS_CNT_RST ##1 lmfc_cnt_q == LSRS_CNT_W'(1))
    else $error("sysref did not realign the multiframe");
  a_sysref_off: assert property (!sysref_receiver_power [*5] |->
    !sysref_evt_q)
    else $error("sysref edge while receiver powered down");
  a_ts_8b10b: assert property (link_mode_64b66b &&
    sync_source_select == LSRS_SYNC_SEL_TS |-> !sync_req)
    else $error("timestamp sync honoured in 64b66b");
  a_cgs_hold: assert property (lane_q.cgs && sync_req |=> lane_q.cgs [*1])
    else $error("cgs stopped while request held");
  a_ilas_len: assert property ($rose(lane_q.data) && !$past(link_mode_64b66b) |->
    $past(lane_q.ilas, LSRS_ILAS_CYC) && !$past(lane_q.ilas, LSRS_ILAS_CYC + 1))
    else $error("alignment sequence wrong length");

endmodule

// ---- dv/lsrs_rx_model.sv ----
// Receiver-side model of the sync request handshake.
// Assumes lane flags from lsrs_sync_ref and a one-cycle request from the bench.
`timescale 1ns/10ps

// ============================================================================
// Sync request driver
// ============================================================================
module lsrs_rx_model
  import lsrs_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire lsrs_lane_s lane,
  input  wire logic       rst,
  input  wire logic       req,
  input  wire logic [7:0] cgs_hold,
  output logic            sync_n
);
  logic [7:0] seen;    // Cycles of sync characters seen
  logic       rst_s;   // Reset as it stood at the edge
  logic       req_s;   // Request as it stood at the edge
  logic       cgs_s;   // Sync characters flag at the edge
  logic [7:0] hold_s;  // Hold count at the edge

  initial sync_n = 1'h1;
  initial seen = 8'h00;

  // Pull low on request, release only after sync characters ran long enough
  // Inputs taken at the edge, so the bench's own 1 ns moves cannot race us
  always @(posedge sys_clk)
  begin
    rst_s  = rst;
    req_s  = req;
    cgs_s  = lane.cgs;
    hold_s = cgs_hold;
    #1;
    if (rst_s)
    begin
      sync_n = 1'h1;
      seen = 8'h00;
    end
    else if (req_s)
    begin
      sync_n = 1'h0;
      seen = 8'h00;
    end
    else if (!sync_n && cgs_s)
    begin
      seen = seen + 8'h01;
      // Large hold plays a slow receiver
      if (seen >= hold_s)
        sync_n = 1'h1;
    end
  end
endmodule

// ---- dv/lsrs_sync_ref_tb.sv ----
// Self-checking bench for the link sync and reference select block.
// Assumes the receiver model file and the design package are compiled first.
`timescale 1ns/10ps

module lsrs_sync_ref_tb
  import lsrs_pkg::*;
;
  logic       sys_clk, rst, pll_use, ref_source_select, single_ended_ref_input;
  logic       diff_clk_input, link_mode_64b66b, sysref_receiver_power, sysref_in;
  logic       req, rx_sync_n, pll_ref_q, ref_is_se_q, sysref_evt_q, lmfc_tick_q;
  logic [1:0] sync_source_select, route;
  logic [7:0] cgs_hold;
  logic [31:0] rnd;
  lsrs_lane_s lane_q, prev;
  logic [2:0] expq[$];    // Expected lane flag sequence
  int         run, n, fails, num_checks;

  // Only the routed pin carries the model's request; the others idle high
  wire se_n  = (route == 2'h0) ? rx_sync_n : 1'h1;
  wire ts_n  = (route == 2'h1) ? rx_sync_n : 1'h1;
  wire alt_n = (route == 2'h2) ? rx_sync_n : 1'h1;

  lsrs_sync_ref dut (.sys_clk, .rst, .pll_use, .ref_source_select,
    .single_ended_ref_input, .diff_clk_input, .link_mode_64b66b, .sync_source_select,
    .single_ended_sync_input_n(se_n), .timestamp_input_n(ts_n),
    .alternate_sync_input_n(alt_n), .sysref_receiver_power, .sysref_in, .lane_q,
    .pll_ref_q, .ref_is_se_q, .sysref_evt_q, .lmfc_tick_q);

  lsrs_rx_model rx (.sys_clk, .lane(lane_q), .rst, .req, .cgs_hold, .sync_n(rx_sync_n));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Inputs move a fixed 1 ns after the edge, clear of sampling
  task automatic tick;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic pulse_req;
    req = 1'h1;
    tick();
    req = 1'h0;
  endtask

  // A wait that ran out of its bound ends the run as a failure
  task automatic bail(input logic hit);
    if (hit)
    begin
      fails++;
      end_sim();
    end
  endtask

  // Bounded wait for the scoreboard to empty
  task automatic drain;
    for (int i = 0; i < 600 && expq.size() > 0; i++)
      tick();
    if (expq.size() > 0)
    begin
      fails++;
      end_sim();
    end
  endtask

  // ==========================================================================
  // Clock, hang guard, lane monitor
  // ==========================================================================
  initial
  begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    end_sim();
  end

  // Every change of lane flags pops the oldest note; ILAS length timed too
  always @(posedge sys_clk)
  begin
    #2;
    if (rst)
    begin
      prev = '0;
      run = 0;
    end
    else if (lane_q !== prev)
    begin
      if (prev === 3'h2 && lane_q === 3'h1)
        check(run, 64);
      check(lane_q, (expq.size() > 0) ? expq.pop_front() : 3'h7);
      prev = lane_q;
      run = 1;
    end
    else
      run++;
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    {pll_use, ref_source_select, single_ended_ref_input, diff_clk_input} = 4'h0;
    {link_mode_64b66b, sysref_receiver_power, sysref_in, req} = 4'h0;
    sync_source_select = 2'h3;
    route = 2'h3;
    cgs_hold = 8'h02;
    rnd = 32'h39C98245;
    rst = 1'h1;
    repeat (12) tick();
    rst = 1'h0;
    // Reference selection, every select pair, random reference levels
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      {pll_use, ref_source_select} = 2'(i);
      {single_ended_ref_input, diff_clk_input} = rnd[1:0];
      repeat (8) tick();
      check(ref_is_se_q, pll_use & ref_source_select);
      check(pll_ref_q, pll_use & (ref_source_select ? rnd[1] : rnd[0]));
    end
    // SYSREF blocked while its receiver is off
    sysref_in = 1'h1;
    n = 0;
    repeat (10) begin tick(); n += int'(sysref_evt_q === 1'h1); end
    check(n, 0);
    sysref_in = 1'h0;
    repeat (6) tick();
    sysref_receiver_power = 1'h1;
    sysref_in = 1'h1;
    n = 0;
    while (sysref_evt_q !== 1'h1 && n < 12)
    begin
      tick();
      n++;
    end
    check(sysref_evt_q, 1'h1);
    bail(sysref_evt_q !== 1'h1);
    n = 0;
    do begin tick(); n++; end while (lmfc_tick_q !== 1'h1 && n < 20);
    check(n >= 15 && n <= 17, 1'h1);
    bail(lmfc_tick_q !== 1'h1);
    n = 0;
    do begin tick(); n++; end while (lmfc_tick_q !== 1'h1 && n < 20);
    check(n, 16);
    bail(lmfc_tick_q !== 1'h1);
    sysref_in = 1'h0;
    // 64B/66B: straight to data, request ignored
    link_mode_64b66b = 1'h1;
    expq.push_back(3'h1);
    tick();
    check(lane_q, 3'h1);
    route = 2'h0;
    sync_source_select = 2'h0;
    pulse_req();
    repeat (12) tick();
    check(lane_q, 3'h1);
    // 8B/10B but pin not selected: still ignored
    sync_source_select = 2'h3;
    link_mode_64b66b = 1'h0;
    repeat (12) tick();
    check(lane_q, 3'h1);
    sync_source_select = 2'h0;
    expq = '{3'h4, 3'h0, 3'h2, 3'h1};
    drain();
    // Timestamp pair as sync, slow receiver
    route = 2'h1;
    sync_source_select = 2'h1;
    cgs_hold = 8'h14;
    expq = '{3'h4, 3'h0, 3'h2, 3'h1};
    pulse_req();
    drain();
    // Alternate pin, request again in mid alignment sequence
    route = 2'h2;
    sync_source_select = 2'h2;
    cgs_hold = 8'h03;
    expq = '{3'h4, 3'h0, 3'h2, 3'h4, 3'h0, 3'h2, 3'h1};
    pulse_req();
    n = 0;
    while (lane_q !== 3'h2 && n < 200)
    begin
      tick();
      n++;
    end
    bail(lane_q !== 3'h2);
    repeat (10) tick();
    pulse_req();
    drain();
    end_sim();
  end
endmodule
